/* core/pcm_frame_synchronizer.sv */
// Purpose: PCM frame synchronizer with source select, sync correlator and lock machine
// Assumes: stream bit clocks far slower than sys_clk, sampled here with three flops
// Notes:
// Notes on behaviour
// - Major frame holds 1 to 1024 minor frames, programmable.
// - Minor frame length in bits includes the sync pattern bits.
// - Sync word length programmable 16 to 64; that many bits compared.
// - With masking on, mask ones exclude that bit from comparison.
// - Each unmasked mismatch is one error; accepted while within allowance.
// - Errors over allowance make a failed check, pushing state down.
// - Slips within allowance tolerated; larger slip counts as failed check.
// - Search moves to check after programmed number of detections.
// - Check moves to lock after programmed number of verifications.
// - Lock drops to check after programmed number of failures.
// - Check returns to search after programmed number of failures.
// - Data-in-search forwards data always; else only while locked.
// - Burst outputs from sync detection, ignores length, while syncs continue.
// - Burst acts as if all four transition counts were zero.
// - Source is one of bit sync, external, or simulator loopback.
// - Channel one external offers single-ended or RS422; channel two single-ended.
// - External data sampled on clock phase 0 or 180 degrees.
// - Auto phase lets the block choose the external clock phase itself.
// - Only one physical input routed at a time, never combined.
// - Lock state reported as 0 search, 1 check, 2 lock.
`timescale 1ns/1ps
`default_nettype none
module pcm_frame_synchronizer #(
  parameter int CHANNEL = 1,
  parameter int MAXSYNC = 64
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pfs_pkg::pfs_stream_t bitsync_in,
  input wire pfs_pkg::pfs_stream_t ext_se_in,
  input wire pfs_pkg::pfs_stream_t ext_rs422_in,
  input wire pfs_pkg::pfs_stream_t loopback_in,
  output logic [1:0] frame_lock_state,
  output logic out_valid,
  output logic out_data,
  output logic out_frame_start,
  output logic [9:0] minor_index
);
  logic [31:0] ctrl_r;
  logic [9:0] minors_r;
  logic [15:0] framelen_r;
  logic [6:0] synclen_r;
  logic [63:0] pattern_r;
  logic [63:0] mask_r;
  logic [6:0] err_allow_r;
  logic [7:0] slip_allow_r;
  pfs_pkg::pfs_crit_t crit_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic ap_valid;
  logic [6:0] synclen_nxt;

  // AHB-Lite slave, zero wait states, always OKAY
  assign ap_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (clk_en) begin
      wr_pend_r <= ap_valid && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_comb begin
    synclen_nxt = hwdata[6:0];
    if (hwdata[6:0] < pfs_pkg::SYNCLEN_MIN) begin
      synclen_nxt = pfs_pkg::SYNCLEN_MIN;
    end else if (hwdata[6:0] > pfs_pkg::SYNCLEN_MAX) begin
      synclen_nxt = pfs_pkg::SYNCLEN_MAX;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r <= pfs_pkg::CTRL_RST;
      minors_r <= pfs_pkg::MINORS_RST;
      framelen_r <= pfs_pkg::FRAMELEN_RST;
      synclen_r <= pfs_pkg::SYNCLEN_RST;
      pattern_r <= 64'h0;
      mask_r <= 64'h0;
      err_allow_r <= 7'h00;
      slip_allow_r <= 8'h00;
      crit_r <= {4{pfs_pkg::CRIT_RST}};
    end else if (clk_en && wr_pend_r) begin
      if (wr_addr_r == pfs_pkg::ADDR_CTRL) begin
        ctrl_r <= hwdata;
      end else if (wr_addr_r == pfs_pkg::ADDR_FRAME) begin
        // minors minus one, length includes sync
        minors_r <= hwdata[25:16];
        framelen_r <= hwdata[15:0];
      end else if (wr_addr_r == pfs_pkg::ADDR_SYNCLEN) begin
        synclen_r <= synclen_nxt;
      end else if (wr_addr_r == pfs_pkg::ADDR_PAT_LO) begin
        pattern_r[31:0] <= hwdata;
      end else if (wr_addr_r == pfs_pkg::ADDR_PAT_HI) begin
        pattern_r[63:32] <= hwdata;
      end else if (wr_addr_r == pfs_pkg::ADDR_MSK_LO) begin
        mask_r[31:0] <= hwdata;
      end else if (wr_addr_r == pfs_pkg::ADDR_MSK_HI) begin
        mask_r[63:32] <= hwdata;
      end else if (wr_addr_r == pfs_pkg::ADDR_ALLOW) begin
        err_allow_r <= hwdata[6:0];
        slip_allow_r <= hwdata[15:8];
      end else if (wr_addr_r == pfs_pkg::ADDR_CRIT) begin
        crit_r <= pfs_pkg::pfs_crit_t'(hwdata);
      end
    end
  end

  // Source selection
  pfs_pkg::pfs_src_t src;
  pfs_pkg::pfs_stream_t ext_sel;
  pfs_pkg::pfs_stream_t raw;
  logic rs422_ok;
  assign src = pfs_pkg::pfs_src_t'(ctrl_r[pfs_pkg::CTRL_SRC_LSB +: 2]);
  // second channel has no differential receiver
  assign rs422_ok = (CHANNEL == 1) && ctrl_r[pfs_pkg::CTRL_RS422];
  assign ext_sel = rs422_ok ? ext_rs422_in : ext_se_in;

  always_comb begin
    case (src)
      pfs_pkg::SRC_EXTERNAL: raw = ext_sel;
      pfs_pkg::SRC_LOOPBACK: raw = loopback_in;
      default: raw = bitsync_in;
    endcase
  end

  // Three-flop synchroniser, stage 1 read only by stage 2
  logic [2:0] clk_sy_r;
  logic [2:0] dat_sy_r;
  logic clk_st_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      clk_sy_r <= 3'h0;
      dat_sy_r <= 3'h0;
      clk_st_r <= 1'b0;
    end else if (clk_en) begin
      clk_sy_r <= {clk_sy_r[1:0], raw.clk};
      dat_sy_r <= {dat_sy_r[1:0], raw.data};
      if (clk_sy_r[1] == clk_sy_r[2]) begin
        clk_st_r <= clk_sy_r[2];
      end
    end
  end

  // phase select, auto mode flips after repeated failures
  logic auto_ph_r;
  logic [2:0] ph_fail_r;
  logic phase;
  logic rise;
  logic fall;
  logic bit_stb;
  assign phase = ctrl_r[pfs_pkg::CTRL_AUTOPH] ? auto_ph_r : ctrl_r[pfs_pkg::CTRL_PHASE];
  assign rise = (clk_sy_r[2] == clk_sy_r[1]) && clk_sy_r[2] && !clk_st_r;
  assign fall = (clk_sy_r[2] == clk_sy_r[1]) && !clk_sy_r[2] && clk_st_r;
  // external party supplies the clock edges used here
  assign bit_stb = ctrl_r[pfs_pkg::CTRL_ENABLE] &&
                   ((src == pfs_pkg::SRC_EXTERNAL && phase) ? fall : rise);

  // Correlator
  logic [MAXSYNC-1:0] shreg_r;
  logic [MAXSYNC-1:0] len_mask;
  logic [MAXSYNC-1:0] cmp_mask;
  logic [MAXSYNC-1:0] diff;
  logic [6:0] err_cnt;
  logic sync_ok;
  always_comb begin
    len_mask = '0;
    for (int i = 0; i < MAXSYNC; i++) begin
      len_mask[i] = (i < int'(synclen_r));
    end
    cmp_mask = ctrl_r[pfs_pkg::CTRL_MASK_EN] ? (len_mask & ~mask_r) : len_mask;
    diff = (shreg_r ^ pattern_r) & cmp_mask;
    err_cnt = 7'h00;
    for (int i = 0; i < MAXSYNC; i++) begin
      err_cnt = err_cnt + {6'h00, diff[i]};
    end
  end
  assign sync_ok = (err_cnt <= err_allow_r);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      shreg_r <= '0;
    end else if (clk_en && bit_stb) begin
      shreg_r <= {shreg_r[MAXSYNC-2:0], dat_sy_r[2]};
    end
  end

  // Lock machine
  pfs_pkg::pfs_lock_t st_r;
  logic [15:0] bitpos_r;
  logic [7:0] cnt_r;
  logic [7:0] slip_r;
  logic [9:0] minor_r;
  logic burst;
  logic at_frame;
  logic hit;
  logic [15:0] sync_end;
  logic good;
  logic bad;
  logic data_ok;
  assign burst = ctrl_r[pfs_pkg::CTRL_BURST];
  // sync occupies the last synclen bits of the frame
  assign sync_end = framelen_r - 16'h0001;
  // verification point one frame after last sync
  assign at_frame = (bitpos_r == sync_end);
  assign hit = sync_ok && bit_stb;
  // verdict at the expected sync point, outside search and burst
  always_comb begin
    good = 1'b0;
    bad = 1'b0;
    if (bit_stb && st_r != pfs_pkg::FL_SEARCH && !burst) begin
      good = at_frame && sync_ok;
      bad = at_frame && !sync_ok;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= pfs_pkg::FL_SEARCH;
      bitpos_r <= 16'h0;
      cnt_r <= 8'h00;
      slip_r <= 8'h00;
      minor_r <= 10'h000;
    end else if (clk_en && bit_stb) begin
      bitpos_r <= at_frame ? 16'h0 : bitpos_r + 16'h0001;
      if (burst) begin
        // zero counts: lock on any sync, stay while syncs keep coming
        // A whole frame length without any sync ends the burst
        if (sync_ok) begin
          st_r <= pfs_pkg::FL_LOCK;
          bitpos_r <= 16'h0;
        end else if (at_frame) begin
          st_r <= pfs_pkg::FL_SEARCH;
        end
        cnt_r <= 8'h00;
      end else begin
        case (st_r)
          pfs_pkg::FL_SEARCH: begin
            if (sync_ok) begin
              bitpos_r <= 16'h0;
              if (cnt_r + 8'h01 >= crit_r.s2c) begin
                st_r <= pfs_pkg::FL_CHECK;
                cnt_r <= 8'h00;
              end else begin
                cnt_r <= cnt_r + 8'h01;
              end
            end
          end
          pfs_pkg::FL_CHECK: begin
            if (at_frame) begin
              if (sync_ok) begin
                slip_r <= 8'h00;
                if (cnt_r + 8'h01 >= crit_r.c2l) begin
                  st_r <= pfs_pkg::FL_LOCK;
                  cnt_r <= 8'h00;
                end else begin
                  cnt_r <= cnt_r + 8'h01;
                end
              end else if (slip_r < slip_allow_r) begin
                slip_r <= slip_r + 8'h01;
              end else if (cnt_r + 8'h01 >= crit_r.c2s) begin
                st_r <= pfs_pkg::FL_SEARCH;
                cnt_r <= 8'h00;
                slip_r <= 8'h00;
              end else begin
                cnt_r <= cnt_r + 8'h01;
              end
            end
          end
          pfs_pkg::FL_LOCK: begin
            if (at_frame) begin
              if (sync_ok) begin
                cnt_r <= 8'h00;
                slip_r <= 8'h00;
              end else if (slip_r < slip_allow_r) begin
                slip_r <= slip_r + 8'h01;
              end else if (cnt_r + 8'h01 >= crit_r.l2c) begin
                st_r <= pfs_pkg::FL_CHECK;
                cnt_r <= 8'h00;
                slip_r <= 8'h00;
              end else begin
                cnt_r <= cnt_r + 8'h01;
              end
            end
          end
          default: st_r <= pfs_pkg::FL_SEARCH;
        endcase
      end
      // minor index wraps after major count
      if ((burst && hit) || good) begin
        minor_r <= (minor_r >= minors_r) ? 10'h000 : minor_r + 10'h001;
      end
    end
  end

  // auto phase: repeated failures in check toggle sampling phase
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      auto_ph_r <= 1'b0;
      ph_fail_r <= 3'h0;
    end else if (clk_en && bit_stb) begin
      if (st_r == pfs_pkg::FL_LOCK) begin
        ph_fail_r <= 3'h0;
      end else if (bad) begin
        if (ph_fail_r == 3'(pfs_pkg::AUTOPH_FAILS - 1)) begin
          ph_fail_r <= 3'h0;
          auto_ph_r <= !auto_ph_r;
        end else begin
          ph_fail_r <= ph_fail_r + 3'h1;
        end
      end
    end
  end

  // data-in-search, burst passes while locked on syncs
  assign data_ok = ctrl_r[pfs_pkg::CTRL_DIS] || (st_r == pfs_pkg::FL_LOCK) || (burst && hit);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      out_data <= 1'b0;
      out_frame_start <= 1'b0;
    end else if (clk_en) begin
      out_valid <= bit_stb && data_ok;
      out_data <= dat_sy_r[2];
      out_frame_start <= bit_stb && data_ok && (good || (burst && hit));
    end
  end

  assign frame_lock_state = st_r;
  assign minor_index = minor_r;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata <= 32'h0;
    end else if (clk_en && ap_valid && !hwrite) begin
      if (haddr[7:0] == pfs_pkg::ADDR_CTRL) begin
        hrdata <= ctrl_r;
      end else if (haddr[7:0] == pfs_pkg::ADDR_FRAME) begin
        hrdata <= {6'h00, minors_r, framelen_r};
      end else if (haddr[7:0] == pfs_pkg::ADDR_SYNCLEN) begin
        hrdata <= {25'h0, synclen_r};
      end else if (haddr[7:0] == pfs_pkg::ADDR_PAT_LO) begin
        hrdata <= pattern_r[31:0];
      end else if (haddr[7:0] == pfs_pkg::ADDR_PAT_HI) begin
        hrdata <= pattern_r[63:32];
      end else if (haddr[7:0] == pfs_pkg::ADDR_MSK_LO) begin
        hrdata <= mask_r[31:0];
      end else if (haddr[7:0] == pfs_pkg::ADDR_MSK_HI) begin
        hrdata <= mask_r[63:32];
      end else if (haddr[7:0] == pfs_pkg::ADDR_ALLOW) begin
        hrdata <= {16'h0, slip_allow_r, 1'b0, err_allow_r};
      end else if (haddr[7:0] == pfs_pkg::ADDR_CRIT) begin
        hrdata <= crit_r;
      end else if (haddr[7:0] == pfs_pkg::ADDR_STATUS) begin
        hrdata <= {10'h0, auto_ph_r, err_cnt, minor_r, 2'h0, st_r};
      end else begin
        hrdata <= 32'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* core/pfs_pkg.sv */
// Purpose: shared constants and carriers for the PCM frame synchronizer
// Assumes: AHB-Lite register access, 32-bit data
// Notes: register offsets are byte addresses
package pfs_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FRAME = 8'h04;
  localparam logic [7:0] ADDR_SYNCLEN = 8'h08;
  localparam logic [7:0] ADDR_PAT_LO = 8'h0C;
  localparam logic [7:0] ADDR_PAT_HI = 8'h10;
  localparam logic [7:0] ADDR_MSK_LO = 8'h14;
  localparam logic [7:0] ADDR_MSK_HI = 8'h18;
  localparam logic [7:0] ADDR_ALLOW = 8'h1C;
  localparam logic [7:0] ADDR_CRIT = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  // CTRL field positions
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_MASK_EN = 2;
  localparam int CTRL_DIS = 3;
  localparam int CTRL_BURST = 4;
  localparam int CTRL_PHASE = 5;
  localparam int CTRL_AUTOPH = 6;
  localparam int CTRL_RS422 = 7;
  localparam int CTRL_ENABLE = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [9:0] MINORS_RST = 10'h000;
  localparam logic [15:0] FRAMELEN_RST = 16'h0080;
  localparam logic [6:0] SYNCLEN_RST = 7'h20;
  localparam logic [6:0] SYNCLEN_MIN = 7'h10;
  localparam logic [6:0] SYNCLEN_MAX = 7'h40;
  localparam logic [7:0] CRIT_RST = 8'h01;
  localparam int AUTOPH_FAILS = 4;
  typedef enum logic [1:0] {
    SRC_BITSYNC,
    SRC_EXTERNAL,
    SRC_LOOPBACK,
    SRC_RSVD
  } pfs_src_t;
  typedef enum logic [1:0] {
    FL_SEARCH = 2'h0,
    FL_CHECK = 2'h1,
    FL_LOCK = 2'h2
  } pfs_lock_t;
  typedef struct packed {
    logic clk;
    logic data;
  } pfs_stream_t;
  typedef struct packed {
    logic [7:0] s2c;
    logic [7:0] c2l;
    logic [7:0] l2c;
    logic [7:0] c2s;
  } pfs_crit_t;
endpackage

/* sim/pfs_monitor.sv */
// Purpose: port checks for the frame synchronizer
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every synchronizer instance
`timescale 1ns/1ps
`default_nettype none
module pfs_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] frame_lock_state,
  input wire logic out_valid,
  input wire logic out_frame_start,
  input wire logic [9:0] minor_index
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ready_high: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  a_state_code: assert property (frame_lock_state != 2'h3)
    else $error("lock state code out of range");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn && clk_en |=>
    frame_lock_state == 2'h0 && !out_valid && minor_index == 10'h000)
    else $error("reset did not clear outputs");
  a_index_step: assert property ($changed(minor_index) |->
    minor_index == $past(minor_index) + 10'h001 || minor_index == 10'h000)
    else $error("minor index moved by other than one or wrap");
  a_valid_spacing: assert property (out_valid |=> !out_valid [*4])
    else $error("forwarded bit pulses too close");
  a_start_locked: assert property (out_frame_start |-> frame_lock_state != 2'h0)
    else $error("frame start flagged while searching");
  a_freeze_holds: assert property (!clk_en |=>
    $stable(frame_lock_state) && $stable(minor_index))
    else $error("state moved while frozen");
  c_lock: cover property (frame_lock_state == 2'h2);
  c_sync: cover property (out_frame_start);
  c_search_data: cover property (out_valid && frame_lock_state == 2'h0);
endmodule
bind pcm_frame_synchronizer pfs_monitor mon_u (
  .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .hreadyout(hreadyout),
  .hresp(hresp), .frame_lock_state(frame_lock_state), .out_valid(out_valid),
  .out_frame_start(out_frame_start), .minor_index(minor_index)
);
`default_nettype wire

/* sim/pfs_stream_src.sv */
// Purpose: serial clock-and-data source feeding the synchronizer
// Assumes: 80 ns bit period, data set while clock low
// Notes: clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module pfs_stream_src (
  input wire logic inv,
  output var pfs_pkg::pfs_stream_t line
);
  logic clk_r = 1'b0;
  logic dat_r = 1'b0;
  assign line = {clk_r ^ inv, dat_r};
  task automatic send(input logic [63:0] v, input int n);
    // Odd offset keeps pin edges off the system clock edges
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      dat_r = v[i];
      #40 clk_r = 1'b1;
      #40 clk_r = 1'b0;
    end
    // Released line shows the inverse, never a stale bit
    dat_r = ~dat_r;
  endtask
endmodule
`default_nettype wire

/* sim/pcm_frame_synchronizer_bench.sv */
// Purpose: self-checking bench for the frame synchronizer
// Assumes: 48-bit frames, 16-bit sync, three minors per major
// Notes: each source gets its own reset and setup
`timescale 1ns/1ps
`default_nettype none
module pcm_frame_synchronizer_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic hsel = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic inv = 1'b0;
  logic [1:0] route = 2'h0;
  pfs_pkg::pfs_stream_t src;
  pfs_pkg::pfs_stream_t junk = 2'b00;
  logic [1:0] frame_lock_state;
  logic out_valid;
  logic out_data;
  logic out_frame_start;
  logic [9:0] minor_index;
  logic [31:0] q;
  logic [9:0] i0;
  int n_fail = 0;
  int checked = 0;
  int nv = 0;
  int n_one = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  // Unselected inputs carry noise so any mixing breaks sync
  always #37 junk <= {~junk.clk, junk.data ^ junk.clk};
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1) nv++;
    if (out_valid === 1'b1 && out_data === 1'b1) n_one++;
  end
  pcm_frame_synchronizer dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hsel(hsel),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .bitsync_in(route == 2'h0 ? src : junk), .ext_se_in(route == 2'h1 ? src : junk),
    .ext_rs422_in(route == 2'h2 ? src : junk), .loopback_in(route == 2'h3 ? src : junk),
    .frame_lock_state(frame_lock_state), .out_valid(out_valid), .out_data(out_data),
    .out_frame_start(out_frame_start), .minor_index(minor_index)
  );
  pfs_stream_src src_u (.inv(inv), .line(src));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic cfg(input logic [31:0] ctrl);
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    ahb(1'b1, pfs_pkg::ADDR_FRAME, 32'h0002_0030);
    ahb(1'b1, pfs_pkg::ADDR_SYNCLEN, 32'h0000_0010);
    ahb(1'b1, pfs_pkg::ADDR_PAT_LO, 32'h0000_EB90);
    ahb(1'b1, pfs_pkg::ADDR_MSK_LO, 32'h0000_000F);
    ahb(1'b1, pfs_pkg::ADDR_ALLOW, 32'h0000_0000);
    ahb(1'b1, pfs_pkg::ADDR_CRIT, 32'h0102_0201);
    ahb(1'b1, pfs_pkg::ADDR_CTRL, ctrl | 32'h0000_0104);
  endtask
  // One 48-bit frame: 16-bit sync, then 32 zero bits, then lock state check
  task automatic fs(input logic [15:0] s, input logic [1:0] e);
    src_u.send({16'h0, s, 32'h0}, 48);
    repeat (8) @(posedge sys_clk);
    chk(32'(frame_lock_state), 32'(e));
  endtask
  task automatic t_regs;
    rdc(pfs_pkg::ADDR_CTRL, pfs_pkg::CTRL_RST);
    rdc(pfs_pkg::ADDR_CRIT, {4{pfs_pkg::CRIT_RST}});
    rdc(pfs_pkg::ADDR_SYNCLEN, {25'h0, pfs_pkg::SYNCLEN_RST});
    rdc(8'h3C, 32'h0);
    ahb(1'b1, pfs_pkg::ADDR_SYNCLEN, 32'h0000_0008);
    rdc(pfs_pkg::ADDR_SYNCLEN, {25'h0, pfs_pkg::SYNCLEN_MIN});
    ahb(1'b1, pfs_pkg::ADDR_SYNCLEN, 32'h0000_007F);
    rdc(pfs_pkg::ADDR_SYNCLEN, {25'h0, pfs_pkg::SYNCLEN_MAX});
    rdc(pfs_pkg::ADDR_STATUS, 32'h0);
    $display("registers done");
  endtask
  task automatic t_lock;
    cfg(32'h0);
    nv = 0;
    fs(16'hEB90, pfs_pkg::FL_CHECK);
    fs(16'hEB90, pfs_pkg::FL_CHECK);
    chk(32'(nv), 32'h0);
    fs(16'hEB90, pfs_pkg::FL_LOCK);
    i0 = minor_index;
    nv = 0;
    n_one = 0;
    fs(16'hEB90, pfs_pkg::FL_LOCK);
    chk(32'(minor_index != i0), 32'h1);
    chk(32'(nv != 0), 32'h1);
    // Whole locked frame forwarded: only the sync word carries ones
    chk(32'(n_one), 32'h8);
    clk_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    clk_en <= 1'b1;
    fs(16'hEB90, pfs_pkg::FL_LOCK);
    fs(16'hEB90, pfs_pkg::FL_LOCK);
    chk(32'(minor_index), 32'(i0));
    fs(16'hEB9F, pfs_pkg::FL_LOCK);
    fs(16'hEA90, pfs_pkg::FL_LOCK);
    fs(16'hEA90, pfs_pkg::FL_CHECK);
    fs(16'hEA90, pfs_pkg::FL_SEARCH);
    $display("lock machine done");
  endtask
  task automatic t_burst;
    cfg(32'h0000_0010);
    nv = 0;
    fs(16'hEB90, pfs_pkg::FL_LOCK);
    src_u.send({28'h0, 16'hEB90, 20'h0}, 36);
    fs(16'hEB90, pfs_pkg::FL_LOCK);
    chk(32'(nv != 0), 32'h1);
    $display("burst done");
  endtask
  task automatic t_slip;
    cfg(32'h0);
    // One sync error and one slip allowed
    ahb(1'b1, pfs_pkg::ADDR_ALLOW, 32'h0000_0101);
    fs(16'hEB90, pfs_pkg::FL_CHECK);
    fs(16'hEB90, pfs_pkg::FL_CHECK);
    fs(16'hEB90, pfs_pkg::FL_LOCK);
    fs(16'hEA90, pfs_pkg::FL_LOCK);
    fs(16'hE890, pfs_pkg::FL_LOCK);
    fs(16'hE890, pfs_pkg::FL_LOCK);
    fs(16'hE890, pfs_pkg::FL_CHECK);
    $display("slip allowance done");
  endtask
  task automatic t_src;
    // rs422 with inverted phase on channel one
    logic [31:0] c [4] = '{32'h0, 32'h1, 32'hA1, 32'hA};
    for (int k = 0; k < 4; k++) begin
      route <= 2'(k);
      inv <= (k == 2);
      cfg(c[k]);
      nv = 0;
      fs(16'hEB90, pfs_pkg::FL_CHECK);
      chk(32'(nv != 0), 32'(k == 3));
      fs(16'hEB90, pfs_pkg::FL_CHECK);
      fs(16'hEB90, pfs_pkg::FL_LOCK);
    end
    $display("sources done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs;
    t_lock;
    t_burst;
    t_slip;
    t_src;
    test_done;
  end
  // About two and a half times the expected run
  initial begin
    #300000;
    n_fail++;
    test_done;
  end
endmodule
`default_nettype wire
